// File: rtl/rsie_pkg.sv
package rsie_pkg;

  // register addresses on the internal register port
  localparam logic [5:0] ADDR_SERDES_CTL  = 6'h06;
  localparam logic [5:0] ADDR_RX_INT_EN   = 6'h07;
  localparam logic [5:0] ADDR_RX_INT_STAT = 6'h08;
  localparam logic [5:0] ADDR_RX_DATA_A   = 6'h09;
  localparam logic [5:0] ADDR_RX_DATA_B   = 6'h0B;

  // reset values
  localparam logic [7:0] INT_EN_RST     = 8'h00;
  localparam logic [2:0] EOF_LEN_RST    = 3'h3;
  localparam logic [7:0] RDATA_RST      = 8'h00;

  // end-of-frame length field in the serializer control register
  localparam int         EOF_LEN_LSB    = 0;
  localparam int         EOF_LEN_W      = 3;

  // each channel owns one nibble of the enable and status registers
  localparam int         NUM_CH         = 2;
  localparam int         CH_STRIDE      = 4;
  localparam int         BIT_FULL       = 0;
  localparam int         BIT_EOF        = 1;
  localparam int         BIT_OVER       = 2;
  localparam int         BIT_UNDER      = 3;
  localparam int         BIT_FLOW       = 2;
  localparam int         BIT_VALID      = 3;

  // receive byte assembly
  localparam int         BYTE_BITS      = 8;
  localparam int         CNT_W          = 4;

  // one bit time from the correlator of a channel
  typedef struct packed {
    logic tick;
    logic valid;
    logic data;
  } rsie_bit_t;

  // one-cycle event pulses from a channel
  typedef struct packed {
    logic full;
    logic eof;
    logic overflow;
    logic underflow;
  } rsie_ev_t;

endpackage

// File: rtl/rsie_rx_chan.sv
`timescale 1ns/1ps
module rsie_rx_chan #(
  parameter int BYTE_BITS = rsie_pkg::BYTE_BITS,
  parameter int EOF_LEN_W = rsie_pkg::EOF_LEN_W
) (
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire logic                  ce,
  input  wire rsie_pkg::rsie_bit_t   rx,
  input  wire logic [EOF_LEN_W-1:0]  eof_len,
  input  wire logic                  data_rd,
  output rsie_pkg::rsie_ev_t         ev,
  output logic [BYTE_BITS-1:0]       data_q,
  output logic                       all_valid,
  output logic                       hold
);

  logic [rsie_pkg::CNT_W-1:0] bit_cnt;
  logic                       started;
  logic [EOF_LEN_W:0]         gap_cnt;
  logic [BYTE_BITS-1:0]       shift;

  wire logic                       tick_valid   = ce & rx.tick & rx.valid;
  wire logic                       tick_gap     = ce & rx.tick & ~rx.valid & started;
  wire logic [EOF_LEN_W:0]         gap_next     = gap_cnt + (EOF_LEN_W+1)'(1);
  // gap must exceed the length, so a length of zero ends on the first gap bit
  wire logic                       eof_hit      = tick_gap & (gap_next > {1'b0, eof_len}); // RL11 RL12
  wire logic                       byte_done    = tick_valid &
                                                  (bit_cnt == rsie_pkg::CNT_W'(BYTE_BITS - 1));
  wire logic                       partial_load = eof_hit & (bit_cnt != '0);
  wire logic                       load         = byte_done | partial_load; // RL15
  wire logic [BYTE_BITS-1:0]       shift_in     = {shift[BYTE_BITS-2:0], rx.data};
  wire logic [BYTE_BITS-1:0]       load_byte    = byte_done ? shift_in : shift;

  wire logic                       next_hold    = load | (hold & ~data_rd);

  assign ev.full      = load;
  assign ev.eof       = eof_hit;
  // a read in the same cycle as the load has taken the old byte in time
  assign ev.overflow  = load & hold & ~data_rd; // RL10
  assign ev.underflow = data_rd & ~hold; // RL9

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bit_cnt <= '0;
      started <= 1'b0;
      gap_cnt <= '0;
      shift   <= '0;
    end else if (tick_valid) begin
      bit_cnt <= byte_done ? '0 : bit_cnt + rsie_pkg::CNT_W'(1);
      started <= 1'b1;
      gap_cnt <= '0;
      // empty shifter after a byte keeps a short frame right-justified
      shift   <= byte_done ? '0 : shift_in;
    end else if (eof_hit) begin
      bit_cnt <= '0;
      started <= 1'b0;
      gap_cnt <= '0;
      shift   <= '0;
    end else if (tick_gap) begin
      gap_cnt <= gap_next;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      data_q    <= '0;
      all_valid <= 1'b0;
    end else if (load) begin
      data_q    <= load_byte;
      all_valid <= byte_done;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hold <= 1'b0;
    end else if (ce) begin
      hold <= next_hold;
    end
  end

endmodule

// File: rtl/rsie_top.sv
`timescale 1ns/1ps
// Function
// RL1: bit 7 enables channel B underflow interrupt
// RL2: bit 6 enables channel B overflow interrupt
// RL3: bit 5 enables channel B end-of-frame interrupt
// RL4: bit 4 enables channel B full interrupt
// RL5: bit 3 enables channel A underflow interrupt
// RL6: bit 2 enables channel A overflow interrupt
// RL7: bit 1 enables channel A end-of-frame interrupt
// RL8: bit 0 enables channel A full interrupt
// RL9: reading empty data register flags underflow
// RL10: loading unread data register flags overflow
// RL11: end-of-frame after valid bit, gap exceeds length
// RL12: length zero ends on first invalid bit
// RL13: end-of-frame interrupt while pending and enabled
// RL14: status read clears pending end-of-frame
// RL15: full on byte or end-of-frame partial load
// RL16: end-of-frame length is three control bits
// RL17: status readable whatever the enables
// RL18: interrupt is OR of enabled pending bits
// RL19: all enable bits zero after reset
module rsie_top #(
  parameter int BYTE_BITS = rsie_pkg::BYTE_BITS,
  parameter int EOF_LEN_W = rsie_pkg::EOF_LEN_W
) (
  input  wire logic                                    sys_clk,
  input  wire logic                                    rst,
  input  wire logic                                    ce,
  input  wire logic [5:0]                              reg_addr,
  input  wire logic                                    reg_wr,
  input  wire logic                                    reg_rd,
  input  wire logic [7:0]                              reg_wdata,
  output logic [7:0]                                   reg_rdata,
  input  wire rsie_pkg::rsie_bit_t [rsie_pkg::NUM_CH-1:0] rx_bit,
  output logic                                         rx_irq
);

  localparam int NCH = rsie_pkg::NUM_CH;
  localparam int STR = rsie_pkg::CH_STRIDE;

  logic [7:0]            int_en;
  logic [EOF_LEN_W-1:0]  eof_len;
  logic [NCH-1:0]        pend_full;
  logic [NCH-1:0]        pend_eof;
  logic [NCH-1:0]        pend_over;
  logic [NCH-1:0]        pend_under;

  // register port decode
  wire logic             sel_ctl      = (reg_addr == rsie_pkg::ADDR_SERDES_CTL);
  wire logic             sel_en       = (reg_addr == rsie_pkg::ADDR_RX_INT_EN);
  wire logic             sel_stat     = (reg_addr == rsie_pkg::ADDR_RX_INT_STAT);
  wire logic             sel_data_a   = (reg_addr == rsie_pkg::ADDR_RX_DATA_A);
  wire logic             sel_data_b   = (reg_addr == rsie_pkg::ADDR_RX_DATA_B);
  wire logic             wr_en        = ce & reg_wr & sel_en;
  wire logic             wr_ctl       = ce & reg_wr & sel_ctl;
  wire logic             stat_rd      = ce & reg_rd & sel_stat;
  wire logic             rd_take      = ce & reg_rd;

  wire logic [NCH-1:0]   data_rd;
  rsie_pkg::rsie_ev_t    ev       [NCH];
  logic [BYTE_BITS-1:0]  data_q   [NCH];
  logic [NCH-1:0]        all_valid;
  logic [NCH-1:0]        hold;

  // set wins over clear for every sticky flag
  wire logic [NCH-1:0]   next_pend_full;
  wire logic [NCH-1:0]   next_pend_eof;
  wire logic [NCH-1:0]   next_pend_over;
  wire logic [NCH-1:0]   next_pend_under;

  wire logic [7:0]       stat_word;
  wire logic [7:0]       pend_word;

  assign data_rd[0] = rd_take & sel_data_a;
  assign data_rd[1] = rd_take & sel_data_b;

  generate
    for (genvar ch = 0; ch < NCH; ch++) begin : g_ch
      rsie_rx_chan #(
        .BYTE_BITS (BYTE_BITS),
        .EOF_LEN_W (EOF_LEN_W)
      ) u_chan (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .ce        (ce),
        .rx        (rx_bit[ch]),
        .eof_len   (eof_len),
        .data_rd   (data_rd[ch]),
        .ev        (ev[ch]),
        .data_q    (data_q[ch]),
        .all_valid (all_valid[ch]),
        .hold      (hold[ch])
      );

      assign next_pend_eof[ch]   = ev[ch].eof | (pend_eof[ch] & ~stat_rd); // RL14
      assign next_pend_over[ch]  = ev[ch].overflow | (pend_over[ch] & ~stat_rd);
      assign next_pend_under[ch] = ev[ch].underflow | (pend_under[ch] & ~stat_rd);
      // full stays pending until its byte is taken
      assign next_pend_full[ch]  = ev[ch].full | (pend_full[ch] & ~data_rd[ch]);

      // status is raw: enables play no part here
      assign stat_word[ch*STR + rsie_pkg::BIT_FULL]  = pend_full[ch]; // RL17
      assign stat_word[ch*STR + rsie_pkg::BIT_EOF]   = pend_eof[ch];
      assign stat_word[ch*STR + rsie_pkg::BIT_FLOW]  = pend_over[ch] | pend_under[ch];
      assign stat_word[ch*STR + rsie_pkg::BIT_VALID] = all_valid[ch] & hold[ch];

      // separate over and under pending so each enable gates only its own cause
      assign pend_word[ch*STR + rsie_pkg::BIT_FULL]  = pend_full[ch];
      assign pend_word[ch*STR + rsie_pkg::BIT_EOF]   = pend_eof[ch];
      assign pend_word[ch*STR + rsie_pkg::BIT_OVER]  = pend_over[ch];
      assign pend_word[ch*STR + rsie_pkg::BIT_UNDER] = pend_under[ch];
    end
  endgenerate

  // enable nibble per channel: full, eof, overflow, underflow from low bit up
  wire logic [7:0]       irq_terms = pend_word & int_en; // RL1 RL2 RL3 RL4 RL5 RL6 RL7 RL8 RL13
  assign rx_irq = |irq_terms; // RL18

  wire logic [7:0]       ctl_word  = 8'(eof_len) << rsie_pkg::EOF_LEN_LSB;

  // unmapped addresses read as zero
  wire logic [7:0]       next_rdata =
    sel_ctl    ? ctl_word :
    sel_en     ? int_en :
    sel_stat   ? stat_word :
    sel_data_a ? 8'(data_q[0]) :
    sel_data_b ? 8'(data_q[1]) :
                 rsie_pkg::RDATA_RST;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      int_en <= rsie_pkg::INT_EN_RST; // RL19
    end else if (wr_en) begin
      int_en <= reg_wdata;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      eof_len <= rsie_pkg::EOF_LEN_RST;
    end else if (wr_ctl) begin
      eof_len <= reg_wdata[rsie_pkg::EOF_LEN_LSB +: EOF_LEN_W]; // RL16
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pend_full  <= '0;
      pend_eof   <= '0;
      pend_over  <= '0;
      pend_under <= '0;
    end else if (ce) begin
      pend_full  <= next_pend_full; // RL15
      pend_eof   <= next_pend_eof; // RL11
      pend_over  <= next_pend_over; // RL10
      pend_under <= next_pend_under; // RL9
    end
  end

  // read data is captured from state before the read's own clears
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= rsie_pkg::RDATA_RST;
    end else if (rd_take) begin
      reg_rdata <= next_rdata;
    end
  end

endmodule

// File: tb/rsie_host.sv
`timescale 1ns/1ps
module rsie_host (
  input  wire logic       sys_clk,
  output logic [5:0]      reg_addr,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic [7:0]      reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr = 6'h3F;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  // released lines show the inverse so stale values never pass
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask
endmodule

// File: tb/rsie_top_asserts.sv
`timescale 1ns/1ps
module rsie_top_asserts #(
  parameter int BYTE_BITS = 8,
  parameter int EOF_LEN_W = 3
) (
  input wire logic                      sys_clk,
  input wire logic                      rst,
  input wire logic                      ce,
  input wire logic [5:0]                reg_addr,
  input wire logic                      reg_wr,
  input wire logic                      reg_rd,
  input wire logic [7:0]                reg_wdata,
  input wire logic [7:0]                reg_rdata,
  input wire rsie_pkg::rsie_bit_t [1:0] rx_bit,
  input wire logic                      rx_irq
);
  logic [7:0] en_q;
  logic [2:0] len_q;
  logic       seen_rx;
  wire tk = rx_bit[0].tick | rx_bit[1].tick;
  wire rg = ce & reg_rd;
  wire wg = ce & reg_wr;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      en_q <= rsie_pkg::INT_EN_RST;
      len_q <= rsie_pkg::EOF_LEN_RST;
      seen_rx <= 1'b0;
    end else begin
      if (wg && reg_addr == rsie_pkg::ADDR_RX_INT_EN) en_q <= reg_wdata;
      if (wg && reg_addr == rsie_pkg::ADDR_SERDES_CTL) len_q <= reg_wdata[2:0];
      if (ce && tk) seen_rx <= 1'b1;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  chk_en_readback: assert property (rg && reg_addr == rsie_pkg::ADDR_RX_INT_EN
    |=> reg_rdata == $past(en_q)) else $error("enable readback wrong");
  chk_ctl_readback: assert property (rg && reg_addr == rsie_pkg::ADDR_SERDES_CTL
    |=> reg_rdata == {5'h00, $past(len_q)}) else $error("length readback wrong");
  chk_zero_en_quiet: assert property (wg && reg_addr == rsie_pkg::ADDR_RX_INT_EN && reg_wdata == 8'h00
    |=> !rx_irq) else $error("irq with no enable");
  chk_irq_rise_cause: assert property ($rose(rx_irq) |-> $past(ce && (reg_wr || reg_rd || tk)))
    else $error("irq rose without cause");
  chk_irq_fall_cause: assert property ($fell(rx_irq) |-> $past(wg || rg))
    else $error("irq fell without access");
  chk_eof_rd_clear: assert property (en_q == 8'h22 && rg && !wg && !tk
    && reg_addr == rsie_pkg::ADDR_RX_INT_STAT |=> !rx_irq) else $error("eof not cleared");
  chk_quiet_status: assert property (!seen_rx && rg && reg_addr == rsie_pkg::ADDR_RX_INT_STAT
    |=> (reg_rdata & 8'hBB) == 8'h00) else $error("status set without receive");
  chk_under_a_irq: assert property (en_q == 8'h08 && !seen_rx && rg && !wg
    && reg_addr == rsie_pkg::ADDR_RX_DATA_A |=> rx_irq) else $error("underflow irq missing");
  cov_under: cover property (en_q == 8'h08 && rx_irq);
  cov_eof: cover property (en_q == 8'h22 && rx_irq);
  cov_len: cover property (wg && reg_addr == rsie_pkg::ADDR_SERDES_CTL);
endmodule
bind rsie_top rsie_top_asserts #(.BYTE_BITS(BYTE_BITS), .EOF_LEN_W(EOF_LEN_W)) rsie_top_asserts_inst (
  .sys_clk(sys_clk), .rst(rst), .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .rx_bit(rx_bit), .rx_irq(rx_irq));

// File: tb/rsie_top_tb_top.sv
`timescale 1ns/1ps
module rsie_top_tb_top;
  logic                      sys_clk;
  logic                      rst;
  logic                      ce;
  logic [5:0]                reg_addr;
  logic                      reg_wr;
  logic                      reg_rd;
  logic [7:0]                reg_wdata;
  logic [7:0]                reg_rdata;
  rsie_pkg::rsie_bit_t [1:0] rx_bit;
  logic                      rx_irq;
  int                        bad_count;
  int                        checks;
  rsie_top rsie_top_inst (.sys_clk, .rst, .ce, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .rx_bit, .rx_irq);
  rsie_host rsie_host_inst (.sys_clk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata);
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("Error at %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic rdc(input logic [5:0] a, input logic [7:0] e);
    logic [7:0] v;
    rsie_host_inst.rd(a, v);
    chk(v, e);
  endtask
  task automatic irqc(input logic e);
    #1;
    chk({7'h00, rx_irq}, {7'h00, e});
  endtask
  task automatic wen(input logic [7:0] d);
    rsie_host_inst.wr(rsie_pkg::ADDR_RX_INT_EN, d);
  endtask
  task automatic wlen(input logic [7:0] d);
    rsie_host_inst.wr(rsie_pkg::ADDR_SERDES_CTL, d);
  endtask
  task automatic rsc(input logic [7:0] e);
    rdc(rsie_pkg::ADDR_RX_INT_STAT, e);
  endtask
  function automatic logic [7:0] nib(int ch, logic [3:0] v);
    return ch ? {v, 4'h0} : {4'h0, v};
  endfunction
  function automatic logic [5:0] da(int ch);
    return ch ? rsie_pkg::ADDR_RX_DATA_B : rsie_pkg::ADDR_RX_DATA_A;
  endfunction
  // ticks spaced one idle cycle apart, msb first
  task automatic bits(input int ch, input int n, input logic v, input logic [7:0] d);
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge sys_clk);
      rx_bit[ch] <= {1'b1, v, d[i]};
      @(posedge sys_clk);
      rx_bit[ch] <= {1'b0, v, ~d[i]};
    end
  endtask
  task automatic t_reset;
    rdc(rsie_pkg::ADDR_RX_INT_EN, 8'h00);
    rdc(rsie_pkg::ADDR_SERDES_CTL, {5'h00, rsie_pkg::EOF_LEN_RST});
    rdc(6'h3F, 8'h00);
    irqc(1'b0);
    $display("t_reset done");
  endtask
  task automatic t_under;
    for (int ch = 0; ch < 2; ch++) begin
      wen(nib(ch, 4'h8));
      rdc(da(ch), 8'h00);
      irqc(1'b1);
      rsc(nib(ch, 4'h4));
      irqc(1'b0);
    end
    $display("t_under done");
  endtask
  task automatic t_byte;
    for (int ch = 0; ch < 2; ch++) begin
      wen(8'h00);
      bits(ch, 8, 1'b1, 8'hA5);
      rsc(nib(ch, 4'h9));
      irqc(1'b0);
      wen(nib(ch, 4'h1));
      irqc(1'b1);
      rdc(da(ch), 8'hA5);
      irqc(1'b0);
    end
    $display("t_byte done");
  endtask
  task automatic t_over;
    for (int ch = 0; ch < 2; ch++) begin
      wen(nib(ch, 4'h4));
      bits(ch, 8, 1'b1, 8'h3C);
      irqc(1'b0);
      bits(ch, 8, 1'b1, 8'hC3);
      irqc(1'b1);
      rsc(nib(ch, 4'hD));
      irqc(1'b0);
      rdc(da(ch), 8'hC3);
    end
    $display("t_over done");
  endtask
  task automatic t_eof;
    for (int ch = 0; ch < 2; ch++) begin
      wlen(8'h00);
      wen(8'h22);
      bits(ch, 3, 1'b1, 8'h05);
      bits(ch, 1, 1'b0, 8'h00);
      irqc(1'b1);
      rsc(nib(ch, 4'h3));
      irqc(1'b0);
      rdc(da(ch), 8'h05);
      wlen(8'hFA);
      rdc(rsie_pkg::ADDR_SERDES_CTL, 8'h02);
      bits(ch, 1, 1'b1, 8'h01);
      bits(ch, 2, 1'b0, 8'h00);
      irqc(1'b0);
      bits(ch, 1, 1'b0, 8'h00);
      irqc(1'b1);
      rsc(nib(ch, 4'h3));
      rdc(da(ch), 8'h01);
    end
    $display("t_eof done");
  endtask
  // clock enable low must swallow both strobes
  task automatic t_hold;
    ce <= 1'b0;
    wen(8'hFF);
    rdc(rsie_pkg::ADDR_RX_DATA_A, 8'h00);
    ce <= 1'b1;
    rdc(rsie_pkg::ADDR_RX_INT_EN, 8'h00);
    rsc(8'h00);
    irqc(1'b0);
    $display("t_hold done");
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // whole run needs a few hundred cycles
  initial begin
    #2000000;
    bad_count++;
    report_and_stop;
  end
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    rx_bit = '0;
    bad_count = 0;
    checks = 0;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset;
    t_hold;
    t_under;
    t_byte;
    t_over;
    t_eof;
    report_and_stop;
  end
endmodule
